//--- pvt_pkg.sv
// Shared constants and carrier types of the panel video sink block.
// Assumes one core clock at 25 MHz; the hot-plug wait and deadline counts derive from it.
`default_nettype none

package pvt_pkg;

  // ****************************************
  // Clock and time figures
  // ****************************************
  localparam int unsigned CLK_KHZ      = 25000; // Core clock rate
  localparam int unsigned HPD_MAX_MS   = 200;   // Latest hot-plug rise
  localparam int unsigned HPD_DELAY_US = 1000;  // Aux start-up wait before hot-plug
  localparam int unsigned US_PER_MS    = 1000;

  // ****************************************
  // Frame geometry
  // ****************************************
  localparam int          LVL_W          = 6;       // Bits per primary
  localparam logic [10:0] ACT_PIX        = 11'h556; // Active clocks per line
  localparam logic [9:0]  ACT_LINES      = 10'h300; // Active lines per frame
  localparam logic [10:0] LINE_TOT_MAX   = 11'h6b4; // Longest line
  localparam logic [9:0]  FRAME_TOT_MAX  = 10'h364; // Longest frame in lines
  localparam logic [10:0] LINE_BLANK_MAX = LINE_TOT_MAX - ACT_PIX;

  // ****************************************
  // Sink register map
  // ****************************************
  localparam int          AUX_ADDR_W      = 20;
  localparam logic [19:0] REG_SINK_VIDEO_STATUS = 20'h00205;
  localparam int          SINK_VIDEO_BIT        = 0;
  localparam logic [7:0]  SINK_VIDEO_STATUS_RST = 8'h00;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic             act; // Active video qualifier
    logic [LVL_W-1:0] red; // Red level, msb first
    logic [LVL_W-1:0] grn; // Green level
    logic [LVL_W-1:0] blu; // Blue level
  } pvt_pix_s;

  localparam int PIX_W = $bits(pvt_pix_s);

  typedef enum logic [1:0] {
    VS_INIT,
    VS_BLACK,
    VS_SHOW
  } pvt_vstate_e;

endpackage : pvt_pkg

`default_nettype wire

//--- pvt_skid2.sv
// Two-entry skid buffer; every output comes from a flip-flop.
// Assumes both sides share one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none

module pvt_skid2
  import pvt_pkg::*;
#(
  parameter int W = PIX_W
) (
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output var  logic         in_ready_ff,
  output var  logic [W-1:0] out_data_ff,
  output var  logic         out_valid_ff,
  input  wire logic         out_ready
);

  logic [W-1:0] skid_data_ff;
  logic         skid_valid_ff;
  wire          in_fire = in_valid & in_ready_ff;
  wire          take    = ~out_valid_ff | out_ready;

  // ****************************************
  // Next state
  // ****************************************
  // Skid entry catches the word in flight while the drain stalls
  wire          nxt_out_valid  = take ? (skid_valid_ff | in_fire) : 1'b1;
  wire [W-1:0]  nxt_out_data   = take ? (skid_valid_ff ? skid_data_ff : in_data) : out_data_ff;
  wire          nxt_skid_valid = take ? 1'b0 : (skid_valid_ff | in_fire);
  wire [W-1:0]  nxt_skid_data  = (!take && in_fire) ? in_data : skid_data_ff;

  // Registers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      out_valid_ff  <= 1'b0;
      skid_valid_ff <= 1'b0;
      in_ready_ff   <= 1'b0;
      out_data_ff   <= '0;
      skid_data_ff  <= '0;
    end else begin
      out_valid_ff  <= nxt_out_valid;
      skid_valid_ff <= nxt_skid_valid;
      in_ready_ff   <= ~nxt_skid_valid; // Full skid stops the source
      out_data_ff   <= nxt_out_data;
      skid_data_ff  <= nxt_skid_data;
    end
  end

endmodule : pvt_skid2

`default_nettype wire

//--- pvt_panel_seq.sv
// Panel sink: frame checking, automatic black video, hot-plug, status reg.
// Assumes the pixel stream and aux requests come from logic on core_clk;
// the debug black-video disable is a board pin and is synchronised here.
//
// What this block and its source must do
// RQ1: six bits per primary, bigger is brighter
// RQ2: one bit means high level, zeros black
// RQ3: framing from qualifier only, syncs ignored
// RQ4: source keeps pixel clock within range
// RQ5: exactly 768 active lines per frame
// RQ6: source keeps frame length within range
// RQ7: exactly 1366 qualified pixels per line
// RQ8: source keeps line length within range
// RQ9: black video from power-up until valid video
// RQ10: hot-plug within limit, aux ready then
// RQ11: valid video shown, status bit set
// RQ12: video loss clears status, shows black
// RQ13: no-video flag forces black video
// RQ14: debug input disables automatic black video
// RQ15: early aux polling is harmlessly refused
// RQ16: source reads capabilities, then trains
// RQ17: source sends idle pattern before video
// RQ18: source orders backlight around stable video
// RQ19: source drops supply soon after video
// RQ20: source backlight power-up spacing
// RQ21: source backlight shutdown spacing
`timescale 1ns/100ps
`default_nettype none

module pvt_panel_seq
  import pvt_pkg::*;
#(
  parameter int unsigned HPD_DLY_CYC = HPD_DELAY_US * CLK_KHZ / US_PER_MS,
  parameter int unsigned LOSS_CYC    = 2 * int'(FRAME_TOT_MAX) * int'(LINE_TOT_MAX),
  parameter int unsigned HPD_MAX_CYC = HPD_MAX_MS * CLK_KHZ
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst_b,
  input  wire pvt_pix_s              pix_in,
  input  wire logic                  pix_in_valid,
  output var  logic                  pix_in_ready_ff,
  output var  pvt_pix_s              pix_out_ff,
  output var  logic                  pix_out_valid_ff,
  input  wire logic                  pix_out_ready,
  input  wire logic                  no_video_flag,
  input  wire logic                  black_off_pin,
  output var  logic                  black_video_ff,
  output var  logic                  video_on_ff,
  output var  logic                  hot_plug_ff,
  input  wire logic                  aux_req,
  input  wire logic [AUX_ADDR_W-1:0] aux_addr,
  output var  logic                  aux_ack_ff,
  output var  logic                  aux_nack_ff,
  output var  logic [7:0]            aux_rdata_ff
);

  // ****************************************
  // Helpers and state
  // ****************************************
  // Saturating count keeps long gaps from wrapping into a false match
  function automatic logic [10:0] sat_inc(input logic [10:0] v);
    sat_inc = (v == 11'h7ff) ? v : v + 11'h1;
  endfunction : sat_inc

  pvt_vstate_e vstate_ff;
  pvt_vstate_e nxt_vstate;
  logic        blk_off_s1_ff;
  logic        blk_off_s2_ff;
  logic        act_prev_ff;
  logic [10:0] act_run_ff;
  logic [10:0] gap_ff;
  logic [9:0]  line_cnt_ff;
  logic        line_bad_ff;
  logic [31:0] hpd_cnt_ff;
  logic [31:0] idle_cnt_ff;
  logic [31:0] por_cnt_ff;
  pvt_pix_s    buf_in;

  // ****************************************
  // Pin synchroniser
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      blk_off_s1_ff <= 1'b0;
      blk_off_s2_ff <= 1'b0;
    end else begin
      blk_off_s1_ff <= black_off_pin;
      blk_off_s2_ff <= blk_off_s1_ff;
    end
  end

  // ****************************************
  // Frame checker
  // ****************************************
  // Only the qualifier frames video; no sync input exists at all  RQ3
  wire beat      = pix_in_valid & pix_in_ready_ff;
  wire line_end  = beat & ~pix_in.act & act_prev_ff;
  wire short_ln  = line_end & (act_run_ff != ACT_PIX); // RQ7
  wire frame_end = beat & ~pix_in.act & (gap_ff == LINE_BLANK_MAX);
  wire frame_ok  = frame_end & ~line_bad_ff & (line_cnt_ff == ACT_LINES); // RQ5
  wire frame_bad = frame_end & ~frame_ok;

  wire [10:0] nxt_act_run  = !beat ? act_run_ff : (pix_in.act ? sat_inc(act_run_ff) : 11'h0);
  wire [10:0] nxt_gap      = !beat ? gap_ff : (pix_in.act ? 11'h0 : sat_inc(gap_ff));
  wire [9:0]  nxt_line_cnt = frame_end ? 10'h0 :
                             (line_end && !short_ln) ? line_cnt_ff + 10'h1 : line_cnt_ff;
  wire        nxt_line_bad = frame_end ? 1'b0 : (line_bad_ff | short_ln);

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      act_prev_ff <= 1'b0;
      act_run_ff  <= 11'h0;
      gap_ff      <= 11'h0;
      line_cnt_ff <= 10'h0;
      line_bad_ff <= 1'b0;
    end else begin
      act_prev_ff <= beat ? pix_in.act : act_prev_ff;
      act_run_ff  <= nxt_act_run;
      gap_ff      <= nxt_gap;
      line_cnt_ff <= nxt_line_cnt;
      line_bad_ff <= nxt_line_bad;
    end
  end

  // ****************************************
  // Power-up and video sequencer
  // ****************************************
  // A stream that dries up without a bad frame still counts as lost
  wire lost     = (idle_cnt_ff >= LOSS_CYC);
  wire hpd_done = (hpd_cnt_ff >= HPD_DLY_CYC);

  always_comb begin
    nxt_vstate = vstate_ff;
    case (vstate_ff)
      VS_INIT:  nxt_vstate = hpd_done ? VS_BLACK : VS_INIT; // RQ10
      VS_BLACK: nxt_vstate = (frame_ok && !no_video_flag) ? VS_SHOW : VS_BLACK; // RQ11
      VS_SHOW:  nxt_vstate = (frame_bad || lost) ? VS_BLACK : // RQ12
                             no_video_flag ? VS_BLACK : VS_SHOW; // RQ13
      default:  nxt_vstate = VS_INIT;
    endcase
  end

  wire [31:0] nxt_hpd_cnt  = hpd_done ? hpd_cnt_ff : hpd_cnt_ff + 32'h1;
  wire [31:0] nxt_idle_cnt = (frame_ok || lost) ? (frame_ok ? 32'h0 : idle_cnt_ff)
                                                : idle_cnt_ff + 32'h1;
  // Debug pin may only suppress the automatic black  RQ14
  wire        black_force  = (vstate_ff != VS_SHOW) & ~blk_off_s2_ff;

  // Black from reset onward, until shown video takes over  RQ9
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      vstate_ff      <= VS_INIT;
      hpd_cnt_ff     <= 32'h0;
      idle_cnt_ff    <= 32'h0;
      hot_plug_ff    <= 1'b0;
      video_on_ff    <= 1'b0;
      black_video_ff <= 1'b1;
    end else begin
      vstate_ff      <= nxt_vstate;
      hpd_cnt_ff     <= nxt_hpd_cnt;
      idle_cnt_ff    <= nxt_idle_cnt;
      hot_plug_ff    <= (nxt_vstate != VS_INIT); // RQ10
      video_on_ff    <= (nxt_vstate == VS_SHOW); // RQ11
      black_video_ff <= (nxt_vstate != VS_SHOW) & ~blk_off_s2_ff; // RQ9
    end
  end

  // ****************************************
  // Aux status register
  // ****************************************
  // Refused before hot-plug so early polling just retries  RQ15
  wire        aux_hit           = (aux_addr == REG_SINK_VIDEO_STATUS);
  wire [7:0]  sink_video_status = SINK_VIDEO_STATUS_RST | (8'(video_on_ff) << SINK_VIDEO_BIT);
  wire [7:0]  nxt_rdata         = (aux_req && hot_plug_ff && aux_hit) ? sink_video_status : 8'h00;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      aux_ack_ff   <= 1'b0;
      aux_nack_ff  <= 1'b0;
      aux_rdata_ff <= 8'h00;
    end else begin
      aux_ack_ff   <= aux_req & hot_plug_ff;
      aux_nack_ff  <= aux_req & ~hot_plug_ff; // RQ15
      aux_rdata_ff <= nxt_rdata; // RQ11
    end
  end

  // ****************************************
  // Pixel path
  // ****************************************
  // Levels pass untouched, one bit per high level; black is all zero  RQ1
  always_comb begin
    buf_in = pix_in;
    if (black_force) begin
      buf_in.red = '0; // RQ2
      buf_in.grn = '0;
      buf_in.blu = '0;
    end
  end

  pvt_skid2 #(.W(PIX_W)) u_buf (
    .core_clk     (core_clk),
    .rst_b        (rst_b),
    .in_data      (buf_in),
    .in_valid     (pix_in_valid),
    .in_ready_ff  (pix_in_ready_ff),
    .out_data_ff  (pix_out_ff),
    .out_valid_ff (pix_out_valid_ff),
    .out_ready    (pix_out_ready)
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      por_cnt_ff <= 32'h0;
    end else begin
      por_cnt_ff <= (por_cnt_ff >= HPD_MAX_CYC) ? por_cnt_ff : por_cnt_ff + 32'h1;
    end
  end

  sequence s_good_frame;
    (vstate_ff == VS_BLACK) ##0 (frame_ok && !no_video_flag);
  endsequence

  sequence s_status_read;
    aux_req && hot_plug_ff && aux_hit ##1 aux_ack_ff;
  endsequence

  AST_HPD_DEADLINE: assert property ((por_cnt_ff >= HPD_MAX_CYC) |-> hot_plug_ff) // RQ10
    else $error("hot-plug late");
  AST_AUX_EARLY: assert property (aux_req && !hot_plug_ff |=> aux_nack_ff && !aux_ack_ff) // RQ15
    else $error("early aux not refused");
  AST_STATUS_READ: assert property (s_status_read |-> aux_rdata_ff[SINK_VIDEO_BIT] == $past(video_on_ff)) // RQ11
    else $error("status bit mismatch");
  AST_SHOW_ON_GOOD: assert property (s_good_frame |=> video_on_ff && !black_video_ff) // RQ11
    else $error("good frame not shown");
  AST_NOVID_BLACK: assert property (no_video_flag && hot_plug_ff |=> !video_on_ff) // RQ13
    else $error("no-video flag ignored");
  AST_LOSS_BLACK: assert property ((vstate_ff == VS_SHOW) && frame_bad |=> !video_on_ff) // RQ12
    else $error("bad frame kept shown");
  AST_SHORT_LINE: assert property (short_ln && !frame_end |=> line_bad_ff) // RQ7
    else $error("wrong line length missed");
  AST_BLACK_HELD: assert property (!video_on_ff && !$past(blk_off_s2_ff) |-> black_video_ff) // RQ9
    else $error("black video missing");
  AST_DBG_OFF: assert property ($past(blk_off_s2_ff) |-> !black_video_ff) // RQ14
    else $error("debug disable ignored");

endmodule : pvt_panel_seq

`default_nettype wire

//--- pvt_src_model.sv
// Video source model: streams pixel beats as lines of qualified pixels.
// Assumes the sink samples on the rising edge; beats change on the falling one.
// Backlight and supply pins never reach the sink; the source orders them
`timescale 1ns/100ps
`default_nettype none

module pvt_src_model
  import pvt_pkg::*;
#(
  parameter int LINE_CLKS   = 1592,
  parameter int FRAME_LINES = 800
) (
  input  wire logic     core_clk,
  input  wire logic     en,
  input  wire logic     slow,
  input  wire logic     ready,
  output var  pvt_pix_s pix,
  output var  logic     valid
);
  // ****************************************
  // Beat generator
  // ****************************************
  int          col  = 0;
  int          row  = 0;
  logic        gap  = 1'b0;
  logic        took = 1'b0;
  logic        vld  = 1'b0; // Idle at start
  pvt_pix_s    beat = '0;
  logic [17:0] rgb  = 18'h00000;

  // One driver for each output
  assign pix   = beat;
  assign valid = vld;

  // Handshake seen at the sampling edge
  always @(posedge core_clk) begin
    took = vld & ready;
  end

  // Hold a beat until taken; at most one beat a clock
  // A slow source idles every other cycle
  always @(negedge core_clk) begin
    if (!vld || took) begin
      gap = ~gap;
      if (en && !(slow && gap)) begin
        vld = 1'b1;
        beat.act = (col < int'(ACT_PIX)) && (row < int'(ACT_LINES));
        {beat.red, beat.grn, beat.blu} = rgb;
        rgb = rgb + 18'h00001;
        if (col == LINE_CLKS - 1) row = (row == FRAME_LINES - 1) ? 0 : row + 1;
        col = (col == LINE_CLKS - 1) ? 0 : col + 1;
      end else begin
        vld  = 1'b0;
        beat = ~beat; // Idle cycles alternate between the last beat and its inverse
      end
    end
  end
endmodule : pvt_src_model
`default_nettype wire

//--- tb.sv
// Testbench of the panel sink: reset, hot-plug, status reads, black stream.
// Assumes the package, design files and source model are compiled first.
`timescale 1ns/100ps
`default_nettype none

module tb;
  import pvt_pkg::*;
  localparam int unsigned HPD_CYC = 8;
  localparam int          LIMIT   = 10000; // Whole run is near 1300 cycles

  logic                  core_clk;
  logic                  rst_b = 1'b0;
  pvt_pix_s              pix_in;
  pvt_pix_s              pix_out_ff;
  logic                  pix_in_valid;
  logic                  pix_in_ready_ff;
  logic                  pix_out_valid_ff;
  logic                  pix_out_ready = 1'b1;
  logic                  no_video_flag = 1'b0;
  logic                  black_off_pin = 1'b0;
  logic                  black_video_ff;
  logic                  video_on_ff;
  logic                  hot_plug_ff;
  logic                  aux_req = 1'b0;
  logic [AUX_ADDR_W-1:0] aux_addr = '0;
  logic                  aux_ack_ff;
  logic                  aux_nack_ff;
  logic [7:0]            aux_rdata_ff;
  logic                  src_en = 1'b0;
  logic                  src_slow = 1'b0;
  int                    mismatches = 0;
  int                    compares = 0;
  int                    cyc = 0;
  int                    n_in = 0;
  int                    n_out = 0;
  logic                  pass_thru = 1'b0;
  wire  [31:0]           out_rgb = {14'h0, pix_out_ff.red, pix_out_ff.grn, pix_out_ff.blu};

  // ****************************************
  // Design and source
  // ****************************************
  pvt_panel_seq #(
    .HPD_DLY_CYC (HPD_CYC),
    .LOSS_CYC    (4000),
    .HPD_MAX_CYC (20)
  ) pvt_panel_seq_inst (
    .core_clk, .rst_b, .pix_in, .pix_in_valid, .pix_in_ready_ff, .pix_out_ff,
    .pix_out_valid_ff, .pix_out_ready, .no_video_flag, .black_off_pin,
    .black_video_ff, .video_on_ff, .hot_plug_ff, .aux_req, .aux_addr,
    .aux_ack_ff, .aux_nack_ff, .aux_rdata_ff
  );

  pvt_src_model pvt_src_model_inst (
    .core_clk (core_clk),
    .en       (src_en),
    .slow     (src_slow),
    .ready    (pix_in_ready_ff),
    .pix      (pix_in),
    .valid    (pix_in_valid)
  );

  // 25 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Beat counts on both sides; ceiling cuts a hang short
  always @(posedge core_clk) begin
    cyc++;
    if (pix_in_valid === 1'b1 && pix_in_ready_ff === 1'b1) n_in++;
    if (pix_out_valid_ff === 1'b1 && pix_out_ready) begin
      check(out_rgb, pass_thru ? 32'(n_out[17:0]) : 32'h0);
      n_out++;
    end
    if (cyc == LIMIT) begin
      mismatches++;
      results();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One read; answer stands for the single cycle after the taking edge
  task automatic aux_read(input logic [19:0] addr, input logic ack, input logic [7:0] data);
    @(negedge core_clk);
    aux_req = 1'b1;
    aux_addr = addr;
    @(negedge core_clk);
    aux_req = 1'b0;
    check({aux_ack_ff, aux_nack_ff, aux_rdata_ff}, {ack, !ack, data});
  endtask : aux_read

  task automatic results();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  // ****************************************
  // Scenarios
  // ****************************************
  // Power-up: black at once, early poll refused, hot-plug on time
  task automatic t_power();
    int n;
    n = 2;
    repeat (6) @(negedge core_clk);
    check({black_video_ff, video_on_ff, hot_plug_ff, pix_out_valid_ff}, 32'h8);
    rst_b = 1'b1;
    aux_read(REG_SINK_VIDEO_STATUS, 1'b0, 8'h00);
    while (hot_plug_ff !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check(n, HPD_CYC + 1);
    aux_read(REG_SINK_VIDEO_STATUS, 1'b1, 8'h00);
    aux_read(REG_SINK_VIDEO_STATUS + 20'h1, 1'b1, 8'h00);
  endtask : t_power

  // Partial frames never count as video; stall fills, drain empties
  task automatic t_stream();
    src_en = 1'b1;
    repeat (600) @(negedge core_clk);
    src_slow = 1'b1;
    no_video_flag = 1'b1;
    repeat (600) @(negedge core_clk);
    check({black_video_ff, video_on_ff}, 32'h2);
    src_slow = 1'b0;
    no_video_flag = 1'b0;
    pix_out_ready = 1'b0;
    repeat (8) @(negedge core_clk);
    check({pix_in_ready_ff, pix_out_valid_ff}, 32'h1);
    pix_out_ready = 1'b1;
    src_en = 1'b0;
    repeat (8) @(negedge core_clk);
    check(n_out, n_in);
    check(pix_out_valid_ff, 32'h0);
    aux_read(REG_SINK_VIDEO_STATUS, 1'b1, 8'h00);
  endtask : t_stream

  // Debug pin lets the source's levels through untouched and in order
  task automatic t_debug();
    int n0;
    n0 = n_out;
    black_off_pin = 1'b1;
    repeat (4) @(negedge core_clk);
    check(black_video_ff, 32'h0);
    pass_thru = 1'b1;
    src_en = 1'b1;
    repeat (40) @(negedge core_clk);
    src_en = 1'b0;
    repeat (8) @(negedge core_clk);
    check(n_out, n_in);
    check(32'(n_out > n0 + 30), 32'h1);
    black_off_pin = 1'b0;
    repeat (4) @(negedge core_clk);
    pass_thru = 1'b0;
    check({black_video_ff, video_on_ff}, 32'h2);
  endtask : t_debug

  // Second reset in mid-run brings back black and drops hot-plug
  task automatic t_rereset();
    rst_b = 1'b0;
    repeat (2) @(negedge core_clk);
    check({black_video_ff, hot_plug_ff, aux_ack_ff}, 32'h4);
    rst_b = 1'b1;
    aux_read(REG_SINK_VIDEO_STATUS, 1'b0, 8'h00);
  endtask : t_rereset

  // Main sequence
  initial begin
    t_power();
    t_stream();
    t_debug();
    t_rereset();
    results();
  end
endmodule : tb
`default_nettype wire
